//--- pci_status_revision_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "pci_status_revision_params.svh"
// How it works
// - Any detected parity error sets bit 31
// - Driving the system error line sets bit 30
// - Master abort as master sets bit 29
// - Target abort as master sets bit 28
// - Event flags stay set until written one
// - Bit 27 always reads zero
// - Bits 26:25 read fixed medium timing 01b
// - Bit 24 needs PERR, mastership, response enabled
// - Bit 23 reads fixed one
// - Bit 20 follows the loaded power-management bit
// - Capability pointer gives first item when listed
// - Bits 22,21 and 19:16 read zero
// - Revision is an 8-bit read-only value
// - Low three revision bits loadable from EEPROM
// - Response disabled only keeps bit 24 clear; bit 31 still sets
module pci_status_revision_regs
  import pci_status_revision_pkg::*;
#(
  parameter logic [7:0] REV_DEFAULT = 8'h01 // Arbitrary stepping value
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Configuration access from the host bridge
  input wire logic cfg_rd_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  // Bus event reports from the bus engines
  input wire logic parity_err_det_i,
  input wire logic serr_drive_i,
  input wire logic master_abort_i,
  input wire logic target_abort_i,
  input wire logic perr_seen_i,
  input wire logic bus_master_op_i,
  // Command register parity response bit
  input wire logic par_resp_en_i,
  // Values from the EEPROM loader
  input wire logic pm_cap_en_i,
  input wire logic eep_rev_valid_i,
  input wire logic [2:0] eep_rev_i,
  // Status view for other header logic
  output logic [15:0] status_hi_o,
  output logic [7:0] revision_o
);

  // ==========================================================
  // Access decode
  logic wr_status;
  logic rd_status;
  logic rd_rev;
  logic rd_capptr;

  // Dword addresses at full width, so the compares stay six bits wide
  localparam logic [7:0] STATUS_ADDR = `STATUS_OFFSET;
  localparam logic [7:0] REV_ADDR = `REVISION_OFFSET;
  localparam logic [7:0] CAPPTR_ADDR = `CAPPTR_OFFSET;

  // Byte address low bits are ignored; every register is one dword
  assign wr_status = cfg_wr_i && (cfg_addr_i[7:2] == STATUS_ADDR[7:2]);
  assign rd_status = cfg_rd_i && (cfg_addr_i[7:2] == STATUS_ADDR[7:2]);
  assign rd_rev = cfg_rd_i && (cfg_addr_i[7:2] == REV_ADDR[7:2]);
  assign rd_capptr = cfg_rd_i && (cfg_addr_i[7:2] == CAPPTR_ADDR[7:2]);

  // ==========================================================
  // Sticky event flags
  event_flags_type flag_q;
  event_flags_type flag_d;
  event_flags_type set_vec;
  event_flags_type clr_vec;
  logic mdpe_event;

  // Bit 24 needs all three conditions; with response off it never sets
  assign mdpe_event = perr_seen_i && bus_master_op_i && par_resp_en_i;

  // Event sources in flag order
  assign set_vec = {parity_err_det_i,
                    serr_drive_i,
                    master_abort_i,
                    target_abort_i,
                    mdpe_event};

  // All flags sit in the top byte, so only that lane clears them
  assign clr_vec = {cfg_wdata_i[`DPE_BIT:`RTA_BIT], cfg_wdata_i[`MDPE_BIT]} &
                   {`FLAG_COUNT{wr_status && cfg_be_i[3]}};

  // Set beats clear so an event in the clearing cycle is kept
  genvar gi;
  generate
    for (gi = 0; gi < `FLAG_COUNT; gi++) begin : g_flag
      assign flag_d[gi] = set_vec[gi] | (flag_q[gi] & ~clr_vec[gi]);
    end
  endgenerate

  // Flag storage; bus reset empties every flag
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      flag_q <= `FLAGS_RESET;
    end else begin
      flag_q <= flag_d;
    end
  end

  // ==========================================================
  // EEPROM-loaded revision and capability enable
  logic [7:0] rev_q;
  logic [7:0] rev_d;
  logic cap_en_q;
  logic cap_en_d;

  // Upper bits stay hardwired; only the low field follows the loader
  always_comb begin
    rev_d = rev_q;
    if (eep_rev_valid_i) begin
      rev_d[`REV_LOW_BITS-1:0] = eep_rev_i;
    end
    cap_en_d = pm_cap_en_i;
  end

  // Stepping value returns after reset until the loader runs again
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rev_q <= REV_DEFAULT;
      cap_en_q <= `CAP_EN_RESET;
    end else begin
      rev_q <= rev_d;
      cap_en_q <= cap_en_d;
    end
  end

  // ==========================================================
  // Status word assembly
  logic [15:0] status_hi;
  devsel_timing_type devsel_timing;

  assign devsel_timing = devsel_medium;

  // Constant fields are built here, so writes cannot reach them
  assign status_hi = {flag_q[4], flag_q[3], flag_q[2], flag_q[1],
                      1'h0,
                      devsel_timing,
                      flag_q[0],
                      `FBB_VALUE,
                      2'h0,
                      cap_en_q,
                      4'h0};

  // ==========================================================
  // Read path
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [2:0] rsel_q;
  logic [2:0] rsel_d;

  // Unmapped dwords read zero; command half belongs elsewhere
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_status) begin
      rdata_d = {status_hi, 16'h0000};
    end else if (rd_rev) begin
      rdata_d = {24'h00_0000, rev_q};
    end else if (rd_capptr && cap_en_q) begin
      rdata_d = {24'h00_0000, `CAP_PTR_VALUE};
    end
    rvalid_d = cfg_rd_i;
    rsel_d = {rd_status, rd_rev, rd_capptr};
  end

  // Read data is registered; it answers one edge after the request
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
      rvalid_q <= 1'h0;
      rsel_q <= 3'h0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      rsel_q <= rsel_d;
    end
  end

  // Outputs
  assign cfg_rdata_o = rdata_q;
  assign cfg_rvalid_o = rvalid_q;
  assign status_hi_o = status_hi;
  assign revision_o = rev_q;

  // ==========================================================
  // Assertions
  property p_dpe_set;
    @(posedge sys_clk_i) disable iff (rst_i)
    parity_err_det_i |=> flag_q[4];
  endproperty
  a_dpe_set: assert property (p_dpe_set) else $error("parity error did not set bit 31");

  property p_sse_set;
    @(posedge sys_clk_i) disable iff (rst_i)
    serr_drive_i |=> flag_q[3];
  endproperty
  a_sse_set: assert property (p_sse_set) else $error("system error did not set bit 30");

  property p_rma_set;
    @(posedge sys_clk_i) disable iff (rst_i)
    master_abort_i |=> flag_q[2] ##1 (flag_q[2] || $past(clr_vec[2]));
  endproperty
  a_rma_set: assert property (p_rma_set) else $error("master abort flag lost");

  property p_rta_set;
    @(posedge sys_clk_i) disable iff (rst_i)
    target_abort_i |=> flag_q[1];
  endproperty
  a_rta_set: assert property (p_rta_set) else $error("target abort did not set bit 28");

  property p_sticky_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
    (flag_q[4] && !(wr_status && cfg_be_i[3] && cfg_wdata_i[`DPE_BIT])) |=> flag_q[4];
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("bit 31 dropped without clear");

  property p_w1c;
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr_status && cfg_be_i[3] && cfg_wdata_i[`SSE_BIT] && !serr_drive_i) |=> !flag_q[3];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear bit 30");

  property p_fixed_fields;
    @(posedge sys_clk_i) disable iff (rst_i)
    (cfg_rvalid_o && rsel_q[2]) |->
      (cfg_rdata_o[`STA_BIT] == 1'h0) && (cfg_rdata_o[`DEVSEL_MSB:`DEVSEL_LSB] == 2'h1) &&
      (cfg_rdata_o[`FBB_BIT] == 1'h1) && (cfg_rdata_o[22:21] == 2'h0) && (cfg_rdata_o[19:16] == 4'h0);
  endproperty
  a_fixed_fields: assert property (p_fixed_fields) else $error("fixed status field wrong");

  property p_mdpe_gate;
    @(posedge sys_clk_i) disable iff (rst_i)
    (!flag_q[0] && !(perr_seen_i && bus_master_op_i && par_resp_en_i)) |=> !flag_q[0];
  endproperty
  a_mdpe_gate: assert property (p_mdpe_gate) else $error("bit 24 set without all conditions");

  property p_mdpe_set;
    @(posedge sys_clk_i) disable iff (rst_i)
    (perr_seen_i && bus_master_op_i && par_resp_en_i) |=> flag_q[0];
  endproperty
  a_mdpe_set: assert property (p_mdpe_set) else $error("bit 24 not set on master parity error");

  property p_caplist;
    @(posedge sys_clk_i) disable iff (rst_i)
    (cfg_rvalid_o && rsel_q[2] && !$past(rst_i, 2)) |-> (cfg_rdata_o[`CAPLIST_BIT] == $past(pm_cap_en_i, 2));
  endproperty
  a_caplist: assert property (p_caplist) else $error("capabilities bit does not follow eeprom");

  property p_capptr;
    @(posedge sys_clk_i) disable iff (rst_i)
    (cfg_rvalid_o && rsel_q[0] && !$past(rst_i, 2)) |->
      (cfg_rdata_o == ($past(pm_cap_en_i, 2) ? {24'h00_0000, `CAP_PTR_VALUE} : 32'h0000_0000));
  endproperty
  a_capptr: assert property (p_capptr) else $error("capability pointer read wrong");

  property p_rev_upper;
    @(posedge sys_clk_i) disable iff (rst_i)
    (cfg_rvalid_o && rsel_q[1]) |-> (cfg_rdata_o[7:3] == REV_DEFAULT[7:3]) && (cfg_rdata_o[31:8] == 24'h00_0000);
  endproperty
  a_rev_upper: assert property (p_rev_upper) else $error("revision upper bits changed");

  property p_rev_load;
    @(posedge sys_clk_i) disable iff (rst_i)
    eep_rev_valid_i |=> (revision_o[2:0] == $past(eep_rev_i)) ##1 (revision_o[2:0] == $past(revision_o[2:0]) ||
      $past(eep_rev_valid_i));
  endproperty
  a_rev_load: assert property (p_rev_load) else $error("revision low bits not loaded");

  property p_reset_clear;
    @(posedge sys_clk_i)
    rst_i |=> (status_hi_o[15:12] == 4'h0) && (status_hi_o[8] == 1'h0) && !cfg_rvalid_o;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear flags");

  property p_zero_write;
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr_status && cfg_wdata_i[31:24] == 8'h00 && set_vec == 5'h00) |=> (flag_q == $past(flag_q));
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("zero write changed a flag");

  property p_no_lane;
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr_status && !cfg_be_i[3] && set_vec == 5'h00) |=> (flag_q == $past(flag_q));
  endproperty
  a_no_lane: assert property (p_no_lane) else $error("write without top lane changed a flag");

  property p_sticky_all;
    @(posedge sys_clk_i) disable iff (rst_i)
    (flag_q != 5'h00) |=> ((flag_q & $past(flag_q) & ~$past(clr_vec)) == ($past(flag_q) & ~$past(clr_vec)));
  endproperty
  a_sticky_all: assert property (p_sticky_all) else $error("event flag dropped without clear");

  property p_rev_read;
    @(posedge sys_clk_i) disable iff (rst_i)
    (cfg_rvalid_o && rsel_q[1]) |-> (cfg_rdata_o[7:0] == $past(revision_o));
  endproperty
  a_rev_read: assert property (p_rev_read) else $error("revision read differs from register");

endmodule
`default_nettype wire

//--- pci_status_revision_params.svh
`ifndef PCI_STATUS_REVISION_PARAMS_SVH
`define PCI_STATUS_REVISION_PARAMS_SVH

// ==========================================================
// Configuration byte offsets
`define STATUS_OFFSET 8'h04
`define REVISION_OFFSET 8'h08
`define CAPPTR_OFFSET 8'h34

// ==========================================================
// Status field positions within the configuration dword
`define DPE_BIT 31
`define SSE_BIT 30
`define RMA_BIT 29
`define RTA_BIT 28
`define STA_BIT 27
`define DEVSEL_MSB 26
`define DEVSEL_LSB 25
`define MDPE_BIT 24
`define FBB_BIT 23
`define CAPLIST_BIT 20

// ==========================================================
// Fixed field values and reset values
`define FLAG_COUNT 5
`define FLAGS_RESET 5'h00
`define FBB_VALUE 1'h1
`define CAP_PTR_VALUE 8'hdc
`define REV_LOW_BITS 3
`define CAP_EN_RESET 1'h0

`endif

//--- pci_status_revision_pkg.sv
package pci_status_revision_pkg;

  // ==========================================================
  // Decode timing encoding of the status word
  typedef enum logic [1:0] {
    devsel_fast = 2'h0,
    devsel_medium = 2'h1,
    devsel_slow = 2'h2,
    devsel_reserved = 2'h3
  } devsel_timing_type;

  // Sticky event flags, msb first: dpe, sse, rma, rta, mdpe
  typedef logic [4:0] event_flags_type;

endpackage

//--- host_bridge_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bridge_model (
  // Clock and read answer
  input wire logic sys_clk_i,
  input wire logic [31:0] cfg_rdata_i,
  input wire logic cfg_rvalid_i,
  // Configuration request
  output logic cfg_rd_o,
  output logic cfg_wr_o,
  output logic [7:0] cfg_addr_o,
  output logic [3:0] cfg_be_o,
  output logic [31:0] cfg_wdata_o
);
  // ==========================================================
  // Bus idle state
  initial begin
    cfg_rd_o = 1'b0;
    cfg_wr_o = 1'b0;
    cfg_addr_o = 8'h00;
    cfg_be_o = 4'h0;
    cfg_wdata_o = 32'h0;
  end

  // Released address, enable and data lines flip and rd/wr drop, so stale values never look like a request
  task automatic release_bus();
    cfg_rd_o <= 1'b0;
    cfg_wr_o <= 1'b0;
    cfg_addr_o <= ~cfg_addr_o;
    cfg_be_o <= ~cfg_be_o;
    cfg_wdata_o <= ~cfg_wdata_o;
  endtask

  // ==========================================================
  // Configuration cycles, one dword each
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge sys_clk_i);
    cfg_wr_o <= 1'b1;
    cfg_addr_o <= a;
    cfg_be_o <= b;
    cfg_wdata_o <= d;
    @(posedge sys_clk_i);
    release_bus();
  endtask

  // Bounded wait for the answer pulse
  task automatic cfg_read(input logic [7:0] a, output logic [31:0] d, output logic ok);
    int n;
    @(posedge sys_clk_i);
    cfg_rd_o <= 1'b1;
    cfg_addr_o <= a;
    @(posedge sys_clk_i);
    release_bus();
    ok = 1'b0;
    d = 32'h0;
    for (n = 0; n < 4 && !ok; n++) begin
      #1;
      if (cfg_rvalid_i === 1'b1) begin
        ok = 1'b1;
        d = cfg_rdata_i;
      end else begin
        @(posedge sys_clk_i);
      end
    end
  endtask
endmodule
`default_nettype wire

//--- pci_status_revision_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pci_status_revision_params.svh"
module pci_status_revision_regs_tb_top;
  import pci_status_revision_pkg::*;
  localparam logic [7:0] REV_SET = 8'h4d; // Arbitrary stepping value
  localparam logic [31:0] BASE = (32'(`FBB_VALUE) << `FBB_BIT) | (32'(devsel_medium) << `DEVSEL_LSB);
  localparam int EV_BIT [4] = '{`DPE_BIT, `SSE_BIT, `RMA_BIT, `RTA_BIT};
  logic sys_clk, rst, rd, wr, rvalid, perr, mst, resp, pm, ld;
  logic [7:0] addr, revision;
  logic [3:0] be, ev;
  logic [31:0] wdata, rdata, e;
  logic [2:0] erev;
  logic [15:0] hi;
  int bad_count, samples_checked, i;

  pci_status_revision_regs #(.REV_DEFAULT(REV_SET)) pci_status_revision_regs_inst (
    .sys_clk_i(sys_clk), .rst_i(rst), .cfg_rd_i(rd), .cfg_wr_i(wr), .cfg_addr_i(addr),
    .cfg_be_i(be), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
    .parity_err_det_i(ev[0]), .serr_drive_i(ev[1]), .master_abort_i(ev[2]),
    .target_abort_i(ev[3]), .perr_seen_i(perr), .bus_master_op_i(mst), .par_resp_en_i(resp),
    .pm_cap_en_i(pm), .eep_rev_valid_i(ld), .eep_rev_i(erev), .status_hi_o(hi), .revision_o(revision));

  host_bridge_model host_bridge_model_inst (
    .sys_clk_i(sys_clk), .cfg_rdata_i(rdata), .cfg_rvalid_i(rvalid), .cfg_rd_o(rd),
    .cfg_wr_o(wr), .cfg_addr_o(addr), .cfg_be_o(be), .cfg_wdata_o(wdata));

  // ==========================================================
  // Clock, verdict and compares
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // A missing answer ends the run at once
  task automatic check_rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] d;
    logic ok;
    host_bridge_model_inst.cfg_read(a, d, ok);
    samples_checked++;
    if (ok !== 1'b1 || d !== x) begin
      bad_count++;
      $display("wrong value at %0t: addr %h read %h want %h", $time, a, d, x);
    end
    if (ok !== 1'b1) end_of_test();
  endtask

  task automatic check_live(input logic [23:0] x);
    @(posedge sys_clk);
    #1;
    samples_checked++;
    if ({hi, revision} !== x) begin
      bad_count++;
      $display("wrong value at %0t: live view %h want %h", $time, {hi, revision}, x);
    end
  endtask

  task automatic cw(input logic [3:0] b, input logic [31:0] d);
    host_bridge_model_inst.cfg_write(`STATUS_OFFSET, b, d);
  endtask

  // One-cycle event with its qualifiers
  task automatic pulse(input logic [3:0] v, input logic p, input logic m, input logic r);
    @(posedge sys_clk);
    ev <= v;
    perr <= p;
    mst <= m;
    resp <= r;
    @(posedge sys_clk);
    ev <= 4'h0;
    perr <= 1'b0;
    mst <= 1'b0;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    {ev, perr, mst, resp, pm, ld, erev} = '0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    check_rd(`STATUS_OFFSET, BASE);
    check_rd(`REVISION_OFFSET, {24'h0, REV_SET});
    check_rd(`CAPPTR_OFFSET, 32'h0);
    host_bridge_model_inst.cfg_write(8'h10, 4'hf, 32'hffffffff);
    check_rd(8'h10, 32'h0);
    $display("test reset_values done");
    for (i = 0; i < 4; i++) begin
      pulse(4'h1 << i, 1'b0, 1'b0, 1'b0);
      e = BASE | (32'h1 << EV_BIT[i]);
      check_rd(`STATUS_OFFSET, e);
      cw(4'h8, 32'h0);
      cw(4'h7, 32'hffffffff);
      cw(4'hf, 32'h0eff0000);
      check_rd(`STATUS_OFFSET, e);
      cw(4'h8, 32'h1 << EV_BIT[i]);
      check_rd(`STATUS_OFFSET, BASE);
    end
    // Event and clear land on one edge; the event has to win
    fork
      pulse(4'h4, 1'b0, 1'b0, 1'b0);
      cw(4'h8, 32'h1 << `RMA_BIT);
    join
    check_rd(`STATUS_OFFSET, BASE | (32'h1 << `RMA_BIT));
    cw(4'h8, 32'h1 << `RMA_BIT);
    check_rd(`STATUS_OFFSET, BASE);
    $display("test event_flags done");
    pulse(4'h1, 1'b1, 1'b1, 1'b0);
    check_rd(`STATUS_OFFSET, BASE | (32'h1 << `DPE_BIT));
    cw(4'h8, 32'hffffffff);
    pulse(4'h0, 1'b1, 1'b0, 1'b1);
    check_rd(`STATUS_OFFSET, BASE);
    pulse(4'h0, 1'b1, 1'b1, 1'b1);
    check_rd(`STATUS_OFFSET, BASE | (32'h1 << `MDPE_BIT));
    cw(4'h8, 32'h1 << `MDPE_BIT);
    check_rd(`STATUS_OFFSET, BASE);
    $display("test data_parity done");
    @(posedge sys_clk);
    pm <= 1'b1;
    erev <= 3'h2;
    ld <= 1'b1;
    @(posedge sys_clk);
    ld <= 1'b0;
    check_rd(`STATUS_OFFSET, BASE | (32'h1 << `CAPLIST_BIT));
    check_rd(`CAPPTR_OFFSET, {24'h0, `CAP_PTR_VALUE});
    host_bridge_model_inst.cfg_write(`REVISION_OFFSET, 4'hf, 32'hff);
    check_rd(`REVISION_OFFSET, {24'h0, REV_SET[7:3], 3'h2});
    check_live({BASE[31:16] | 16'h0010, REV_SET[7:3], 3'h2});
    $display("test cap_revision done");
    // Reset in mid-run must drop flags and the loaded revision
    pulse(4'hf, 1'b1, 1'b1, 1'b1);
    check_rd(`STATUS_OFFSET, BASE | 32'hf110_0000);
    @(posedge sys_clk);
    rst <= 1'b1;
    pm <= 1'b0;
    @(posedge sys_clk);
    rst <= 1'b0;
    check_live({BASE[31:16], REV_SET});
    check_rd(`STATUS_OFFSET, BASE);
    check_rd(`REVISION_OFFSET, {24'h0, REV_SET});
    $display("test mid_reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
